// ---- ctm_pkg.sv ----
// Purpose: Shared constants of the compact timer block.
// Assumes: Byte-wide register port with a three-bit address.
// Notes: Register offsets, field positions, codes and divider counts.
package ctm_pkg;
    localparam int CTM_AW = 3;
    localparam logic [2:0] CTM_OFS_CTRL0 = 3'h0;
    localparam logic [2:0] CTM_OFS_CTRL1 = 3'h1;
    localparam logic [2:0] CTM_OFS_CNT_LO = 3'h2;
    localparam logic [2:0] CTM_OFS_CNT_HI = 3'h3;
    localparam logic [2:0] CTM_OFS_CMPA_LO = 3'h4;
    localparam logic [2:0] CTM_OFS_CMPA_HI = 3'h5;
    localparam logic [2:0] CTM_OFS_STATUS = 3'h6;
    localparam int CTM_C0_PAUSE = 7;
    localparam int CTM_C0_CK_LSB = 4;
    localparam int CTM_C0_ON = 3;
    localparam int CTM_C0_RP_LSB = 0;
    localparam int CTM_C1_MODE_LSB = 6;
    localparam int CTM_C1_IO_LSB = 4;
    localparam int CTM_C1_OC = 3;
    localparam int CTM_C1_POL = 2;
    localparam int CTM_C1_DPX = 1;
    localparam int CTM_C1_CCLR = 0;
    localparam int CTM_ST_FA = 0;
    localparam int CTM_ST_FP = 1;
    localparam logic [7:0] CTM_CTRL_RST = 8'h00;
    localparam logic [9:0] CTM_CMPA_RST = 10'h000;
    localparam logic [9:0] CTM_CNT_RST = 10'h000;
    localparam logic [1:0] CTM_MODE_CMP = 2'h0;
    localparam logic [1:0] CTM_MODE_PWM = 2'h2;
    localparam logic [1:0] CTM_MODE_TMR = 2'h3;
    localparam logic [1:0] CTM_IO_NONE = 2'h0;
    localparam logic [1:0] CTM_IO_LOW = 2'h1;
    localparam logic [1:0] CTM_IO_HIGH = 2'h2;
    localparam logic [1:0] CTM_IO_TOGGLE = 2'h3;
    localparam logic [1:0] CTM_IO_PWM = 2'h2;
    localparam logic [2:0] CTM_CK_SYS4 = 3'h0;
    localparam logic [2:0] CTM_CK_SYS = 3'h1;
    localparam logic [2:0] CTM_CK_H16 = 3'h2;
    localparam logic [2:0] CTM_CK_H64 = 3'h3;
    localparam logic [2:0] CTM_CK_SUB0 = 3'h4;
    localparam logic [2:0] CTM_CK_SUB1 = 3'h5;
    localparam logic [2:0] CTM_CK_EXT_RISE = 3'h6;
    localparam logic [2:0] CTM_CK_EXT_FALL = 3'h7;
    localparam logic [5:0] CTM_PRE4_MASK = 6'h03;
    localparam logic [5:0] CTM_PRE16_MASK = 6'h0F;
    localparam logic [5:0] CTM_PRE64_MASK = 6'h3F;
    localparam int CTM_SUB_DIV = 610;
    localparam logic [10:0] CTM_FULL_SPAN = 11'h400;
endpackage

// ---- ctm_tick_if.sv ----
// Purpose: Clock-select request and timer tick between timer and tick source.
// Assumes: Both ends run on the system clock.
// Notes: The tick is a one-cycle pulse per timer clock.
`timescale 1ns/1ps
`default_nettype none
interface ctm_tick_if;
    logic [2:0] clk_sel;
    logic tick;
    modport gen (input clk_sel, output tick);
    modport user (output clk_sel, input tick);
endinterface
`default_nettype wire

// ---- ctm_tick_gen.sv ----
// Purpose: Timer clock tick generator with prescalers and external pin.
// Assumes: The high clock equals the system clock here.
// Notes: The external pin passes two flip-flops before edge detection.
`timescale 1ns/1ps
`default_nettype none
module ctm_tick_gen #(
    parameter int SUB_DIV = ctm_pkg::CTM_SUB_DIV
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ext_clk_i,
    ctm_tick_if.gen tick_bus
);
    localparam int SW = $clog2(SUB_DIV);
    logic [5:0] pre;
    logic [5:0] next_pre;
    logic [SW-1:0] sub;
    logic [SW-1:0] next_sub;
    logic [2:0] sync;
    logic [2:0] next_sync;
    logic tick;
    logic next_tick;

    always_comb begin
        next_pre = pre + 6'h01;
        next_sub = (sub == SW'(SUB_DIV - 1)) ? '0 : sub + SW'(1);
        next_sync = {sync[1:0], ext_clk_i};
        case (tick_bus.clk_sel)
            ctm_pkg::CTM_CK_SYS4:
                next_tick = (pre & ctm_pkg::CTM_PRE4_MASK) == ctm_pkg::CTM_PRE4_MASK;
            ctm_pkg::CTM_CK_SYS: next_tick = 1'b1;
            ctm_pkg::CTM_CK_H16:
                next_tick = (pre & ctm_pkg::CTM_PRE16_MASK) == ctm_pkg::CTM_PRE16_MASK;
            ctm_pkg::CTM_CK_H64: next_tick = pre == ctm_pkg::CTM_PRE64_MASK;
            ctm_pkg::CTM_CK_SUB0,
            ctm_pkg::CTM_CK_SUB1: next_tick = sub == SW'(SUB_DIV - 1);
            ctm_pkg::CTM_CK_EXT_RISE: next_tick = sync[1] & ~sync[2];
            ctm_pkg::CTM_CK_EXT_FALL: next_tick = ~sync[1] & sync[2];
            default: next_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pre <= 6'h00;
            sub <= '0;
            sync <= 3'h0;
            tick <= 1'b0;
        end else begin
            pre <= next_pre;
            sub <= next_sub;
            sync <= next_sync;
            tick <= next_tick;
        end
    end

    assign tick_bus.tick = tick;
endmodule
`default_nettype wire

// ---- ctm_timer.sv ----
// Purpose: Compact 10-bit timer with comparators A and P and one output pin.
// Assumes: Byte register port, read data valid the cycle after the strobe.
// Notes: Status flags clear by writing one; a new match wins over the clear.
// Summary of operation
// - Counter readable as low byte plus two bits
// - Compare A held in low and high registers
// - Mode field picks compare, PWM or timer
// - Clear-select low: P match or overflow clears
// - Clear-select high: A match clears, no P flag
// - Clear-select high, A value zero: run to 3FF, no flag
// - Compare mode pin changes only on A match
// - Pin action: high, low, toggle or none
// - On rising edge loads initial pin level
// - Timer mode counts alike but leaves pin free
// - PWM ignores clear-select; role swap picks roles
// - PWM raises A and P flags on matches
// - PWM polarity, forced levels and invert bit
// - Swap zero: period is code times 128
// - Duty at or above period holds the active level
// - Swap one: A sets period, code sets duty
// - PWM counting continues while pin is forced
// - On rising edge clears counter; off holds it
// - Pause freezes counter, release resumes counting
// - P compares code times 128 with counter plus one
// - Clock select picks internal or pin clock
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ctm_timer #(
    parameter int SUB_DIV = ctm_pkg::CTM_SUB_DIV
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [ctm_pkg::CTM_AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic external_clock_pin_i,
    output logic timer_output_pin_o,
    output logic timer_output_en_o,
    output logic match_a_flag_o,
    output logic match_p_flag_o
);
    ctm_tick_if tick_bus ();

    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [9:0] cmpa;
    logic [9:0] cnt;
    logic flag_a;
    logic flag_p;
    logic on_q;
    logic pin_lvl;
    logic pin_o;
    logic pin_en;
    logic [7:0] rdata;

    logic [7:0] next_ctrl0;
    logic [7:0] next_ctrl1;
    logic [9:0] next_cmpa;
    logic [9:0] next_cnt;
    logic next_flag_a;
    logic next_flag_p;
    logic next_pin_lvl;
    logic next_pin_o;
    logic next_pin_en;
    logic [7:0] next_rdata;

    logic on;
    logic pause;
    logic [2:0] code;
    logic [1:0] mode;
    logic [1:0] io;
    logic oc;
    logic pol;
    logic dpx;
    logic cclr;
    logic pwm;
    logic on_rise;
    logic run;
    logic [9:0] cnt_inc;
    logic a_hit;
    logic p_hit;
    logic a_ok;
    logic clr;
    logic ev_a;
    logic ev_p;
    logic [10:0] duty;
    logic pwm_act;
    logic pwm_lvl;
    logic wr_st;
    logic [1:0] cnt_hi;

    ctm_tick_gen #(
        .SUB_DIV(SUB_DIV)
    ) u_tick (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .ext_clk_i(external_clock_pin_i),
        .tick_bus(tick_bus.gen)
    );

    assign tick_bus.clk_sel = ctrl0[ctm_pkg::CTM_C0_CK_LSB +: 3];

    // Field decode of the two control registers.
    always_comb begin
        on = ctrl0[ctm_pkg::CTM_C0_ON];
        pause = ctrl0[ctm_pkg::CTM_C0_PAUSE];
        code = ctrl0[ctm_pkg::CTM_C0_RP_LSB +: 3];
        mode = ctrl1[ctm_pkg::CTM_C1_MODE_LSB +: 2];
        io = ctrl1[ctm_pkg::CTM_C1_IO_LSB +: 2];
        oc = ctrl1[ctm_pkg::CTM_C1_OC];
        pol = ctrl1[ctm_pkg::CTM_C1_POL];
        dpx = ctrl1[ctm_pkg::CTM_C1_DPX];
        cclr = ctrl1[ctm_pkg::CTM_C1_CCLR];
        pwm = mode == ctm_pkg::CTM_MODE_PWM;
        cnt_hi = cnt[9:8];
    end

    // Counter, comparators and match flags.
    always_comb begin
        on_rise = on & ~on_q;
        run = on & ~pause & tick_bus.tick;
        cnt_inc = cnt + 10'h001;
        a_hit = cnt == cmpa;
        // P match sits on the last count before a multiple of 128, so code 0
        // falls on the overflow from 3FF.
        p_hit = cnt_inc == {code, 7'h00};
        a_ok = cmpa != 10'h000;
        if (pwm) begin
            clr = dpx ? a_hit : p_hit;
            ev_a = run & a_hit;
            ev_p = run & p_hit;
        end else if (cclr) begin
            clr = a_hit & a_ok;
            ev_a = run & a_hit & a_ok;
            ev_p = 1'b0;
        end else begin
            clr = p_hit;
            ev_a = run & a_hit;
            ev_p = run & p_hit;
        end
        next_cnt = cnt;
        if (on_rise) begin
            next_cnt = ctm_pkg::CTM_CNT_RST;
        end else if (run) begin
            next_cnt = clr ? ctm_pkg::CTM_CNT_RST : cnt_inc;
        end
        wr_st = wr_i & (addr_i == ctm_pkg::CTM_OFS_STATUS);
        next_flag_a = ev_a | (flag_a & ~(wr_st & wdata_i[ctm_pkg::CTM_ST_FA]));
        next_flag_p = ev_p | (flag_p & ~(wr_st & wdata_i[ctm_pkg::CTM_ST_FP]));
    end

    // PWM duty compare and pin level.
    always_comb begin
        if (dpx) begin
            duty = (code == 3'h0) ? ctm_pkg::CTM_FULL_SPAN : {1'b0, code, 7'h00};
        end else begin
            duty = {1'b0, cmpa};
        end
        // Counter never reaches the period, so duty at or above it stays active.
        pwm_act = {1'b0, cnt} < duty;
        case (io)
            ctm_pkg::CTM_IO_NONE: pwm_lvl = ~oc;
            ctm_pkg::CTM_IO_LOW: pwm_lvl = oc;
            ctm_pkg::CTM_IO_PWM: pwm_lvl = pwm_act ? oc : ~oc;
            default: pwm_lvl = ~oc;
        endcase
        next_pin_lvl = pin_lvl;
        if (mode == ctm_pkg::CTM_MODE_CMP) begin
            if (on_rise) begin
                next_pin_lvl = oc;
            end else if (ev_a) begin
                case (io)
                    ctm_pkg::CTM_IO_LOW: next_pin_lvl = 1'b0;
                    ctm_pkg::CTM_IO_HIGH: next_pin_lvl = 1'b1;
                    ctm_pkg::CTM_IO_TOGGLE: next_pin_lvl = ~pin_lvl;
                    default: next_pin_lvl = pin_lvl;
                endcase
            end
        end
        case (mode)
            ctm_pkg::CTM_MODE_CMP: begin
                next_pin_o = next_pin_lvl ^ pol;
                next_pin_en = 1'b1;
            end
            ctm_pkg::CTM_MODE_PWM: begin
                next_pin_o = pwm_lvl ^ pol;
                next_pin_en = 1'b1;
            end
            default: begin
                next_pin_o = 1'b0;
                next_pin_en = 1'b0;
            end
        endcase
    end

    // Register writes and read data.
    always_comb begin
        next_ctrl0 = ctrl0;
        next_ctrl1 = ctrl1;
        next_cmpa = cmpa;
        if (wr_i) begin
            case (addr_i)
                ctm_pkg::CTM_OFS_CTRL0: next_ctrl0 = wdata_i;
                ctm_pkg::CTM_OFS_CTRL1: next_ctrl1 = wdata_i;
                ctm_pkg::CTM_OFS_CMPA_LO: next_cmpa[7:0] = wdata_i;
                ctm_pkg::CTM_OFS_CMPA_HI: next_cmpa[9:8] = wdata_i[1:0];
                default: next_cmpa = cmpa;
            endcase
        end
        next_rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                ctm_pkg::CTM_OFS_CTRL0: next_rdata = ctrl0;
                ctm_pkg::CTM_OFS_CTRL1: next_rdata = ctrl1;
                ctm_pkg::CTM_OFS_CNT_LO: next_rdata = cnt[7:0];
                ctm_pkg::CTM_OFS_CNT_HI: next_rdata = {6'h00, cnt_hi};
                ctm_pkg::CTM_OFS_CMPA_LO: next_rdata = cmpa[7:0];
                ctm_pkg::CTM_OFS_CMPA_HI: next_rdata = {6'h00, cmpa[9:8]};
                ctm_pkg::CTM_OFS_STATUS: next_rdata = {6'h00, flag_p, flag_a};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl0 <= ctm_pkg::CTM_CTRL_RST;
            ctrl1 <= ctm_pkg::CTM_CTRL_RST;
            cmpa <= ctm_pkg::CTM_CMPA_RST;
            cnt <= ctm_pkg::CTM_CNT_RST;
            flag_a <= 1'b0;
            flag_p <= 1'b0;
            on_q <= 1'b0;
            pin_lvl <= 1'b0;
            pin_o <= 1'b0;
            pin_en <= 1'b0;
            rdata <= 8'h00;
        end else begin
            ctrl0 <= next_ctrl0;
            ctrl1 <= next_ctrl1;
            cmpa <= next_cmpa;
            cnt <= next_cnt;
            flag_a <= next_flag_a;
            flag_p <= next_flag_p;
            on_q <= on;
            pin_lvl <= next_pin_lvl;
            pin_o <= next_pin_o;
            pin_en <= next_pin_en;
            rdata <= next_rdata;
        end
    end

    assign rdata_o = rdata;
    assign timer_output_pin_o = pin_o;
    assign timer_output_en_o = pin_en;
    assign match_a_flag_o = flag_a;
    assign match_p_flag_o = flag_p;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    cnt_hi_read_a: assert property (
        rd_i && addr_i == ctm_pkg::CTM_OFS_CNT_HI |=> rdata_o == {6'h00, $past(cnt_hi)})
        else $error("count high read wrong");

    cmpa_hi_write_a: assert property (
        wr_i && addr_i == ctm_pkg::CTM_OFS_CMPA_HI ##1 !wr_i
        ##1 rd_i && addr_i == ctm_pkg::CTM_OFS_CMPA_HI
        |=> rdata_o == {6'h00, $past(wdata_i, 3) & 8'h03})
        else $error("compare A high readback wrong");

    on_clear_a: assert property (
        on_rise |=> cnt == ctm_pkg::CTM_CNT_RST)
        else $error("counter not cleared on start");

    pause_hold_a: assert property (
        pause && !on_rise |=> $stable(cnt))
        else $error("counter moved while paused");

    p_clear_a: assert property (
        run && !pwm && !cclr && p_hit && !on_rise |=> cnt == 10'h000 && flag_p)
        else $error("P match did not clear or flag");

    a_clear_a: assert property (
        run && !pwm && cclr && !on_rise |=> !flag_p || $past(flag_p))
        else $error("P flag raised with clear-select high");

    zero_a_wrap_a: assert property (
        run && !pwm && cclr && cmpa == 10'h000 && cnt == 10'h3FF && !on_rise && !flag_a
        |=> cnt == 10'h000 && !flag_a)
        else $error("zero A value misbehaved at overflow");

    cmp_pin_hold_a: assert property (
        mode == ctm_pkg::CTM_MODE_CMP && $past(mode) == ctm_pkg::CTM_MODE_CMP
        && $stable(pol) && !ev_a && !on_rise && !wr_i |=> $stable(timer_output_pin_o))
        else $error("pin moved without A match");

    on_init_a: assert property (
        mode == ctm_pkg::CTM_MODE_CMP && on_rise && !wr_i |=> timer_output_pin_o == (oc ^ pol))
        else $error("pin not set to initial level");

    tmr_release_a: assert property (
        mode == ctm_pkg::CTM_MODE_TMR && !wr_i |=> !timer_output_en_o)
        else $error("timer mode still drives pin");

    flag_set_wins_a: assert property (
        ev_a ##0 wr_st |=> flag_a)
        else $error("match lost against clear");

    pwm_swap_clear_a: assert property (
        run && pwm && dpx && a_hit && !on_rise |=> cnt == 10'h000)
        else $error("A match did not end the PWM period");

    pwm_period_clear_a: assert property (
        run && pwm && !dpx && p_hit && !on_rise |=> cnt == 10'h000)
        else $error("P match did not end the PWM period");

    pwm_a_flag_a: assert property (
        run && pwm && a_hit && !on_rise |=> flag_a)
        else $error("PWM A match flag missing");

    pwm_p_flag_a: assert property (
        run && pwm && p_hit && !on_rise |=> flag_p)
        else $error("PWM P match flag missing");

    pwm_full_duty_a: assert property (
        pwm && !dpx && io == ctm_pkg::CTM_IO_PWM && code != 3'h0 && !wr_i
        && cnt < {code, 7'h00} && cmpa >= {code, 7'h00} |=> timer_output_pin_o == (oc ^ pol))
        else $error("full duty PWM left its active level");

    pwm_forced_run_a: assert property (
        run && pwm && !dpx && io != ctm_pkg::CTM_IO_PWM && !p_hit && !on_rise
        |=> cnt == $past(cnt) + 10'h001)
        else $error("PWM count stopped while pin forced");

    p_boundary_a: assert property (
        run && !pwm && !cclr && !on_rise && cnt[6:0] != 7'h7F |=> cnt != 10'h000)
        else $error("P match away from a 128 boundary");

    sys_tick_a: assert property (
        tick_bus.clk_sel == ctm_pkg::CTM_CK_SYS |=> tick_bus.tick)
        else $error("system clock select gave no tick");

    cmp_set_high_a: assert property (
        mode == ctm_pkg::CTM_MODE_CMP && ev_a && io == ctm_pkg::CTM_IO_HIGH && !on_rise && !wr_i
        |=> timer_output_pin_o == ~pol)
        else $error("pin action high not applied");
endmodule
`default_nettype wire

// ---- ctm_load_model.sv ----
// Purpose: Load on the timer output pin that measures the waveform it receives.
// Assumes: The pin is sampled on the system clock.
// Notes: Totals count only while the pin is driven; a released pin is not measured.
`timescale 1ns/1ps
`default_nettype none
module ctm_load_model (
    input wire logic clk_sys_i,
    input wire logic clr_i,
    input wire logic pin_i,
    input wire logic en_i,
    output logic [15:0] hi_total_o,
    output logic [15:0] lo_total_o,
    output logic [15:0] hi_len_o
);
    logic [15:0] run;
    always_ff @(posedge clk_sys_i) begin
        if (clr_i) begin
            hi_total_o <= 16'h0000;
            lo_total_o <= 16'h0000;
        end else if (en_i) begin
            hi_total_o <= hi_total_o + 16'(pin_i);
            lo_total_o <= lo_total_o + 16'(!pin_i);
        end
        run <= pin_i ? run + 16'h0001 : 16'h0000;
        // The length of a high pulse is kept once the pulse has ended.
        if (!pin_i && run != 16'h0000) begin
            hi_len_o <= run;
        end
    end
endmodule
`default_nettype wire

// ---- test_compact_timer_module.sv ----
// Purpose: Self-checking bench of the compact timer.
// Assumes: Subsidiary divider shortened to 4; external clock toggles every 5 cycles.
// Notes: Flag periods are measured from one set edge to the next.
`timescale 1ns/1ps
`default_nettype none
module test_compact_timer_module;
    localparam int SUB = 4;
    typedef struct {
        logic [7:0] c0;
        logic [7:0] c1;
        logic [9:0] a;
        logic use_p;
        int per;
        logic [7:0] st;
        logic en;
    } ctm_row_s;
    logic clk_sys_i, reset_i, wr_i, rd_i, ext_i, clr, pin, en, fa, fp, lvl;
    logic [2:0] addr_i;
    logic [7:0] wdata_i, rdata_o, v, w;
    logic [15:0] hi_t, lo_t, hi_len;
    int n_errors = 0;
    int checked = 0;
    int n, i, k;
    ctm_row_s rows [11] = '{
        '{8'h00, 8'h01, 10'h003, 1'b0, 16, 8'h01, 1'b1},
        '{8'h10, 8'h01, 10'h003, 1'b0, 4, 8'h01, 1'b1},
        '{8'h20, 8'h01, 10'h003, 1'b0, 64, 8'h01, 1'b1},
        '{8'h30, 8'h01, 10'h003, 1'b0, 256, 8'h01, 1'b1},
        '{8'h40, 8'h01, 10'h003, 1'b0, 4 * SUB, 8'h01, 1'b1},
        '{8'h50, 8'h01, 10'h003, 1'b0, 4 * SUB, 8'h01, 1'b1},
        '{8'h60, 8'h01, 10'h003, 1'b0, 40, 8'h01, 1'b1},
        '{8'h70, 8'h01, 10'h003, 1'b0, 40, 8'h01, 1'b1},
        '{8'h11, 8'h00, 10'h003, 1'b1, 128, 8'h03, 1'b1},
        '{8'h10, 8'hC1, 10'h00A, 1'b0, 11, 8'h01, 1'b0},
        '{8'h11, 8'hA9, 10'h020, 1'b1, 128, 8'h03, 1'b1}
    };
    logic [7:0] pc1 [6] = '{8'hA8, 8'hAC, 8'hA0, 8'hA8, 8'h98, 8'h88};
    logic [9:0] pa [6] = '{10'h020, 10'h020, 10'h020, 10'h080, 10'h020, 10'h020};
    logic [15:0] phi [6] = '{16'h0040, 16'h00C0, 16'h00C0, 16'h0100, 16'h0100, 16'h0000};

    ctm_timer #(.SUB_DIV(SUB)) i_ctm_timer (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .external_clock_pin_i(ext_i),
        .timer_output_pin_o(pin), .timer_output_en_o(en), .match_a_flag_o(fa),
        .match_p_flag_o(fp));
    ctm_load_model i_ctm_load_model (.clk_sys_i(clk_sys_i), .clr_i(clr), .pin_i(pin),
        .en_i(en), .hi_total_o(hi_t), .lo_total_o(lo_t), .hi_len_o(hi_len));

    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    // The pin clock is offset so that its edges never meet a system clock edge.
    initial begin
        ext_i = 1'b0;
        #13;
        forever #250 ext_i = ~ext_i;
    end

    task automatic conclude();
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
        logic [7:0] q;
        wr(a, d);
        rd(a, q);
        chk(16'(q), 16'(e));
    endtask
    // Switches off, loads compare A and control, clears flags, then switches on.
    task automatic setup(input logic [7:0] c0, input logic [7:0] c1, input logic [9:0] a);
        wr(3'h0, c0);
        wr(3'h4, a[7:0]);
        wr(3'h5, {6'h00, a[9:8]});
        wr(3'h1, c1);
        wr(3'h6, 8'h03);
        wr(3'h0, c0 | 8'h08);
    endtask
    task automatic wait_flag(input logic use_p, output int cnt);
        cnt = 0;
        do begin
            @(posedge clk_sys_i);
            #1;
            cnt++;
        end while ((use_p ? fp : fa) !== 1'b1 && cnt < 3000);
        if (cnt >= 3000) begin
            n_errors++;
            $display("FAIL %0t flag wait timed out", $time);
            conclude();
        end
    endtask

    initial begin
        reset_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 3'h0;
        wdata_i = 8'h00;
        clr = 1'b0;
        repeat (12) @(posedge clk_sys_i);
        chk(16'({en, pin, fa, fp}), 16'h0000);
        reset_i <= 1'b0;
        for (k = 0; k < 8; k++) begin
            rd(k[2:0], v);
            chk(16'(v), 16'h0000);
        end
        wr_rd(3'h4, 8'hA5, 8'hA5);
        wr_rd(3'h5, 8'hFF, 8'h03);
        wr_rd(3'h2, 8'h55, 8'h00);
        wr_rd(3'h3, 8'hFF, 8'h00);
        wr_rd(3'h7, 8'h55, 8'h00);
        foreach (rows[r]) begin
            setup(rows[r].c0, rows[r].c1, rows[r].a);
            wait_flag(rows[r].use_p, n);
            wr(3'h6, 8'h03);
            wait_flag(rows[r].use_p, n);
            chk(16'(n + 2), 16'(rows[r].per));
            rd(3'h6, v);
            chk(16'(v), 16'(rows[r].st));
            chk(16'(en), 16'(rows[r].en));
        end
        setup(8'h10, 8'h01, 10'h000);
        repeat (1100) @(posedge clk_sys_i);
        #1;
        chk(16'({fa, fp}), 16'h0000);
        setup(8'h10, 8'h00, 10'h3FF);
        repeat (20) @(posedge clk_sys_i);
        wr(3'h0, 8'h98);
        rd(3'h2, v);
        rd(3'h2, w);
        chk(16'(w), 16'(v));
        wr(3'h0, 8'h18);
        rd(3'h2, w);
        chk(16'(w != v), 16'h0001);
        wr(3'h0, 8'h10);
        rd(3'h2, v);
        repeat (5) @(posedge clk_sys_i);
        rd(3'h2, w);
        chk(16'(w), 16'(v));
        wr(3'h0, 8'h18);
        rd(3'h2, v);
        chk(16'(v < 8'h08), 16'h0001);
        rd(3'h3, v);
        chk(16'(v), 16'h0000);
        for (k = 0; k < 8; k++) begin
            lvl = k[2];
            setup(8'h11, {2'b00, k[1:0], k[2], 3'b000}, 10'h00A);
            repeat (3) @(posedge clk_sys_i);
            #1;
            chk(16'(pin), 16'(lvl));
            for (i = 0; i < 2; i++) begin
                wait_flag(1'b0, n);
                case (k[1:0])
                    2'h1: lvl = 1'b0;
                    2'h2: lvl = 1'b1;
                    2'h3: lvl = ~lvl;
                    default: lvl = lvl;
                endcase
                chk(16'(pin), 16'(lvl));
                wr(3'h6, 8'h03);
            end
        end
        for (k = 0; k < 6; k++) begin
            setup(8'h11, pc1[k], pa[k]);
            repeat (300) @(posedge clk_sys_i);
            clr <= 1'b1;
            @(posedge clk_sys_i);
            clr <= 1'b0;
            wr(3'h6, 8'h03);
            repeat (254) @(posedge clk_sys_i);
            #1;
            chk(hi_t, phi[k]);
            chk(lo_t, 16'h0100 - phi[k]);
            chk(16'(fp), 16'h0001);
        end
        setup(8'h11, 8'hAA, 10'h0C7);
        repeat (600) @(posedge clk_sys_i);
        #1;
        chk(hi_len, 16'h0080);
        conclude();
    end
endmodule
`default_nettype wire
